//--- verilog/slip_irq_defines.svh
// Offsets, field positions, reset values and sizes of the slip interrupt block
`ifndef SLIP_IRQ_DEFINES_SVH
`define SLIP_IRQ_DEFINES_SVH

// Register offsets on the register port
`define SLIP_STATUS_ADDR 8'h08
`define SLIP_ENABLE_ADDR 8'h09

// Bit positions, shared by the enable and the status register
`define SLIP_TX_OVERFLOW_BIT 7
`define SLIP_TX_UNDERFLOW_BIT 6
`define SLIP_TX_ANY_BIT 5
`define SLIP_RX_OVERFLOW_BIT 2
`define SLIP_RX_UNDERFLOW_BIT 1
`define SLIP_RX_ANY_BIT 0

// Reset value, writable bits and reserved bits
`define SLIP_REG_RESET 8'h00
`define SLIP_WRITABLE_MASK 8'he7
`define SLIP_RESERVED_MASK 8'h18

// Buffer depth in whole frames and width of the level count
`define SLIP_DEPTH_FRAMES 2
`define SLIP_LEVEL_W 8

`endif

//--- verilog/slip_irq_pkg.sv
// Types shared by the slip interrupt block
package slip_irq_pkg;

  // One register image, enable and status alike
  typedef logic [7:0] slip_reg_t;

  // Buffer occupancy in frames
  typedef logic [7:0] slip_level_t;

endpackage

//--- verilog/slip_path_if.sv
// Frame strobes and slip events between the top and one slip buffer
`timescale 1ns/1ps
interface slip_path_if;
  logic frame_wr;
  logic frame_rd;
  logic drop;
  logic dup;
  slip_irq_pkg::slip_level_t level;

  modport buffer (input frame_wr, input frame_rd,
                  output drop, output dup, output level);
  modport ctrl (output frame_wr, output frame_rd,
                input drop, input dup, input level);
endinterface

//--- verilog/slip_frame_buffer.sv
// Frame-granular slip buffer occupancy with overflow and underflow slips
`timescale 1ns/1ps
`include "slip_irq_defines.svh"
module slip_frame_buffer #(
  parameter int DEPTH = `SLIP_DEPTH_FRAMES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Frame strobes in, slip events out
  slip_path_if.buffer path
);

  logic full;
  logic empty;

  assign full = (path.level == slip_irq_pkg::slip_level_t'(DEPTH));
  assign empty = (path.level == '0);

  // Occupancy count; a slip leaves it unchanged
  always_ff @(posedge core_clk) begin
    if (srst) begin
      path.level <= '0;
    end else if (path.frame_wr && !path.frame_rd && !full) begin
      path.level <= path.level + 1'b1;
    end else if (path.frame_rd && !path.frame_wr && !empty) begin
      path.level <= path.level - 1'b1;
    end
  end

  // Write into a full buffer drops a frame; read of empty repeats one
  always_ff @(posedge core_clk) begin
    if (srst) begin
      path.drop <= 1'b0;
      path.dup <= 1'b0;
    end else begin
      path.drop <= path.frame_wr && !path.frame_rd && full;
      path.dup <= path.frame_rd && !path.frame_wr && empty;
    end
  end

  sequence s_write_full;
    path.frame_wr && !path.frame_rd && full;
  endsequence

  sequence s_read_empty;
    path.frame_rd && !path.frame_wr && empty;
  endsequence

  a_overflow_drop_frame: assert property (
    @(posedge core_clk) disable iff (srst)
    s_write_full |=> path.drop && $stable(path.level))
    else $error("full buffer write did not drop a frame");

  a_underflow_repeat_frame: assert property (
    @(posedge core_clk) disable iff (srst)
    s_read_empty |=> path.dup && path.level == '0)
    else $error("empty buffer read did not repeat a frame");

endmodule

//--- verilog/slip_buffer_interrupt_enable.sv
// Slip buffer interrupt enable, sticky status and interrupt of one channel
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "slip_irq_defines.svh"

////////////////////////////////////////////////////////////////////////////////

// Functional notes
// - Enable bit 7 lets a transmit buffer overflow raise its interrupt.
// - Writing into a full buffer drops one frame and flags overflow.
// - Enable bit 6 lets a transmit buffer underflow raise its interrupt.
// - Reading an empty buffer repeats one frame and flags underflow.
// - Enable bit 5 covers any transmit slip, overflow or underflow.
// - Enable bit 2 lets a receive buffer overflow raise its interrupt.
// - Enable bits are read-write, reset to 0; 1 enables, 0 disables.
// - An enabled slip event sets its status bit to one.
// - Status bits clear when software reads the status register.
// - Bit 1 enables receive underflow, bit 0 any receive slip.
module slip_buffer_interrupt_enable #(
  parameter int DEPTH = `SLIP_DEPTH_FRAMES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Transmit slip buffer frame strobes and slips
  input wire logic tx_frame_wr,
  input wire logic tx_frame_rd,
  output logic tx_frame_drop,
  output logic tx_frame_repeat,
  output logic [7:0] tx_level,
  // Receive slip buffer frame strobes and slips
  input wire logic rx_frame_wr,
  input wire logic rx_frame_rd,
  output logic rx_frame_drop,
  output logic rx_frame_repeat,
  output logic [7:0] rx_level,
  // Interrupt request, level, active high
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Slip buffers

  slip_path_if tx_path ();
  slip_path_if rx_path ();

  // Frame strobes into the two buffers
  assign tx_path.frame_wr = tx_frame_wr;
  assign tx_path.frame_rd = tx_frame_rd;
  assign rx_path.frame_wr = rx_frame_wr;
  assign rx_path.frame_rd = rx_frame_rd;

  slip_frame_buffer #(
    .DEPTH(DEPTH)
  ) tx_buffer (
    .core_clk(core_clk),
    .srst(srst),
    .path(tx_path)
  );

  slip_frame_buffer #(
    .DEPTH(DEPTH)
  ) rx_buffer (
    .core_clk(core_clk),
    .srst(srst),
    .path(rx_path)
  );

  // Slip pulses and levels, all from buffer flip-flops
  assign tx_frame_drop = tx_path.drop;
  assign tx_frame_repeat = tx_path.dup;
  assign tx_level = tx_path.level;
  assign rx_frame_drop = rx_path.drop;
  assign rx_frame_repeat = rx_path.dup;
  assign rx_level = rx_path.level;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode

  slip_irq_pkg::slip_reg_t slip_irq_enable_reg;
  slip_irq_pkg::slip_reg_t slip_status;
  slip_irq_pkg::slip_reg_t slip_events;
  slip_irq_pkg::slip_reg_t next_slip_status;
  slip_irq_pkg::slip_reg_t next_slip_irq_enable_reg;
  logic enable_wr;
  logic status_rd;
  logic enable_rd;

  assign enable_wr = reg_wr && (reg_addr == `SLIP_ENABLE_ADDR);
  assign enable_rd = reg_rd && (reg_addr == `SLIP_ENABLE_ADDR);
  assign status_rd = reg_rd && (reg_addr == `SLIP_STATUS_ADDR);

  //////////////////////////////////////////////////////////////////////////////
  // Enable register

  // Software-written enables; reserved bits forced to zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      slip_irq_enable_reg <= `SLIP_REG_RESET;
    end else if (enable_wr) begin
      slip_irq_enable_reg <= reg_wdata & `SLIP_WRITABLE_MASK;
    end
  end

  // Enable value after this edge; a new mask reaches the interrupt at once
  always_comb begin
    next_slip_irq_enable_reg = slip_irq_enable_reg;
    if (enable_wr) begin
      next_slip_irq_enable_reg = reg_wdata & `SLIP_WRITABLE_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Slip events gated by their enables

  always_comb begin
    slip_events = '0;
    slip_events[`SLIP_TX_OVERFLOW_BIT] = tx_path.drop &&
      slip_irq_enable_reg[`SLIP_TX_OVERFLOW_BIT];
    slip_events[`SLIP_TX_UNDERFLOW_BIT] = tx_path.dup &&
      slip_irq_enable_reg[`SLIP_TX_UNDERFLOW_BIT];
    slip_events[`SLIP_TX_ANY_BIT] = (tx_path.drop || tx_path.dup) &&
      slip_irq_enable_reg[`SLIP_TX_ANY_BIT];
    slip_events[`SLIP_RX_OVERFLOW_BIT] = rx_path.drop &&
      slip_irq_enable_reg[`SLIP_RX_OVERFLOW_BIT];
    slip_events[`SLIP_RX_UNDERFLOW_BIT] = rx_path.dup &&
      slip_irq_enable_reg[`SLIP_RX_UNDERFLOW_BIT];
    slip_events[`SLIP_RX_ANY_BIT] = (rx_path.drop || rx_path.dup) &&
      slip_irq_enable_reg[`SLIP_RX_ANY_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by a read; a new event wins over the clear

  always_comb begin
    next_slip_status = slip_status;
    if (status_rd) begin
      next_slip_status = '0;
    end
    next_slip_status = next_slip_status | slip_events;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      slip_status <= `SLIP_REG_RESET;
    end else begin
      slip_status <= next_slip_status;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (status_rd) begin
      reg_rdata <= slip_status;
    end else if (enable_rd) begin
      reg_rdata <= slip_irq_enable_reg;
    end else begin
      reg_rdata <= '0; // Unmapped or idle reads zero
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt output

  // Level while any enabled status bit stands
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_slip_status & next_slip_irq_enable_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_status_read;
    status_rd;
  endsequence

  sequence s_quiet_events;
    !tx_path.drop && !tx_path.dup && !rx_path.drop && !rx_path.dup;
  endsequence

  sequence s_status_write;
    reg_wr && !reg_rd && reg_addr == `SLIP_STATUS_ADDR;
  endsequence

  a_enable_reset_zero: assert property (
    @(posedge core_clk)
    srst |=> slip_irq_enable_reg == '0 && slip_status == '0)
    else $error("enable or status not zero after reset");

  a_enable_write_lands: assert property (
    @(posedge core_clk) disable iff (srst)
    enable_wr |=> slip_irq_enable_reg ==
      ($past(reg_wdata) & `SLIP_WRITABLE_MASK))
    else $error("enable register did not take the write");

  a_tx_overflow_flag: assert property (
    @(posedge core_clk) disable iff (srst)
    tx_frame_wr && !tx_frame_rd && tx_level == 8'(DEPTH) &&
      slip_irq_enable_reg[`SLIP_TX_OVERFLOW_BIT] && !enable_wr
      |=> ##1 slip_status[`SLIP_TX_OVERFLOW_BIT])
    else $error("transmit overflow did not set its status");

  a_tx_underflow_flag: assert property (
    @(posedge core_clk) disable iff (srst)
    tx_path.dup && slip_irq_enable_reg[`SLIP_TX_UNDERFLOW_BIT]
      |=> slip_status[`SLIP_TX_UNDERFLOW_BIT])
    else $error("transmit underflow did not set its status");

  a_tx_any_slip: assert property (
    @(posedge core_clk) disable iff (srst)
    (tx_path.drop || tx_path.dup) &&
      slip_irq_enable_reg[`SLIP_TX_ANY_BIT]
      |=> slip_status[`SLIP_TX_ANY_BIT])
    else $error("transmit slip did not set the combined status");

  a_rx_overflow_flag: assert property (
    @(posedge core_clk) disable iff (srst)
    rx_path.drop && slip_irq_enable_reg[`SLIP_RX_OVERFLOW_BIT]
      |=> slip_status[`SLIP_RX_OVERFLOW_BIT])
    else $error("receive overflow did not set its status");

  a_rx_under_any: assert property (
    @(posedge core_clk) disable iff (srst)
    rx_path.dup && slip_irq_enable_reg[`SLIP_RX_UNDERFLOW_BIT] &&
      slip_irq_enable_reg[`SLIP_RX_ANY_BIT]
      |=> slip_status[`SLIP_RX_UNDERFLOW_BIT] &&
        slip_status[`SLIP_RX_ANY_BIT])
    else $error("receive underflow did not set its status bits");

  a_disabled_stays_clear: assert property (
    @(posedge core_clk) disable iff (srst)
    ((slip_irq_enable_reg == '0) and s_status_read) |=> slip_status == '0)
    else $error("status set while all enables were off");

  a_reserved_read_zero: assert property (
    @(posedge core_clk) disable iff (srst)
    ((slip_irq_enable_reg | slip_status) & `SLIP_RESERVED_MASK) == '0)
    else $error("reserved bits are not zero");

  a_read_clears_status: assert property (
    @(posedge core_clk) disable iff (srst)
    s_status_read ##0 s_quiet_events
      |=> slip_status == '0 && reg_rdata == $past(slip_status))
    else $error("status read did not return and clear");

  a_irq_follows_status: assert property (
    @(posedge core_clk) disable iff (srst)
    irq == |(slip_status & slip_irq_enable_reg))
    else $error("interrupt does not match enabled status");

  a_enable_holds: assert property (
    @(posedge core_clk) disable iff (srst)
    !enable_wr |=> $stable(slip_irq_enable_reg))
    else $error("enable register changed without a write");

  a_disabled_bit_quiet: assert property (
    @(posedge core_clk) disable iff (srst)
    (slip_status & ~$past(slip_status) &
      ~$past(slip_irq_enable_reg)) == '0)
    else $error("status bit rose while its enable was off");

  a_status_sticky: assert property (
    @(posedge core_clk) disable iff (srst)
    !status_rd |=> ($past(slip_status) & ~slip_status) == '0)
    else $error("status bit cleared without a status read");

  a_status_write_ignored: assert property (
    @(posedge core_clk) disable iff (srst)
    s_status_write ##0 s_quiet_events |=> $stable(slip_status))
    else $error("write to the status register changed it");

  a_tx_overflow_cause: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(slip_status[`SLIP_TX_OVERFLOW_BIT]) |->
      $past(tx_path.drop))
    else $error("transmit overflow status rose with no drop");

  a_tx_underflow_cause: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(slip_status[`SLIP_TX_UNDERFLOW_BIT]) |->
      $past(tx_path.dup))
    else $error("transmit underflow status rose with no repeat");

  a_tx_any_cause: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(slip_status[`SLIP_TX_ANY_BIT]) |->
      $past(tx_path.drop || tx_path.dup))
    else $error("transmit combined status rose with no slip");

  a_rx_overflow_cause: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(slip_status[`SLIP_RX_OVERFLOW_BIT]) |->
      $past(rx_path.drop))
    else $error("receive overflow status rose with no drop");

  a_rx_underflow_cause: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(slip_status[`SLIP_RX_UNDERFLOW_BIT]) |->
      $past(rx_path.dup))
    else $error("receive underflow status rose with no repeat");

  a_rx_any_cause: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(slip_status[`SLIP_RX_ANY_BIT]) |->
      $past(rx_path.drop || rx_path.dup))
    else $error("receive combined status rose with no slip");

  a_rdata_idle_zero: assert property (
    @(posedge core_clk) disable iff (srst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside a read");

  a_enable_readback: assert property (
    @(posedge core_clk) disable iff (srst)
    enable_rd |=> reg_rdata == $past(slip_irq_enable_reg))
    else $error("enable read returned the wrong value");

  a_irq_reset_low: assert property (
    @(posedge core_clk)
    srst |=> !irq)
    else $error("interrupt not low after reset");

  a_level_bounded: assert property (
    @(posedge core_clk) disable iff (srst)
    tx_level <= 8'(DEPTH) && rx_level <= 8'(DEPTH))
    else $error("buffer level beyond its depth");

  a_slip_exclusive: assert property (
    @(posedge core_clk) disable iff (srst)
    !(tx_path.drop && tx_path.dup) && !(rx_path.drop && rx_path.dup))
    else $error("a buffer dropped and repeated in one cycle");

endmodule

//--- verification/slip_buffer_interrupt_enable_test.sv
// Self-checking bench for the slip buffer interrupt enable block
`timescale 1ns/1ps
`include "slip_irq_defines.svh"
module slip_buffer_interrupt_enable_test;
  localparam int DEPTH = 2;
  localparam logic [7:0] ST = `SLIP_STATUS_ADDR;
  localparam logic [7:0] EN = `SLIP_ENABLE_ADDR;
  logic core_clk, srst, reg_wr, reg_rd, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_level, rx_level;
  logic tx_frame_wr, tx_frame_rd, tx_frame_drop, tx_frame_repeat;
  logic rx_frame_wr, rx_frame_rd, rx_frame_drop, rx_frame_repeat;
  int miscompares, total_checks, cycles, tx_lv, rx_lv;
  slip_irq_pkg::slip_reg_t exp_en, exp_st, got;
  logic [31:0] seed, r;

  slip_buffer_interrupt_enable #(.DEPTH(DEPTH)) dut (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_frame_wr(tx_frame_wr),
    .tx_frame_rd(tx_frame_rd), .tx_frame_drop(tx_frame_drop),
    .tx_frame_repeat(tx_frame_repeat), .tx_level(tx_level),
    .rx_frame_wr(rx_frame_wr), .rx_frame_rd(rx_frame_rd),
    .rx_frame_drop(rx_frame_drop), .rx_frame_repeat(rx_frame_repeat),
    .rx_level(rx_level), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic slip_irq_pkg::slip_reg_t slip_bits(input bit tx,
      input bit ovf, input bit und);
    slip_irq_pkg::slip_reg_t m;
    m = {ovf, und, ovf | und, 2'b00, ovf, und, ovf | und};
    return tx ? (m & 8'he0) : (m & 8'h07);
  endfunction

  // Comparisons
  task automatic chk_val(input string n, input logic [7:0] e,
      input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == EN) exp_en = d & `SLIP_WRITABLE_MASK;
    @(posedge core_clk); // Idle cycle keeps strobe writes apart
  endtask
  task automatic rd_chk(input logic [7:0] a, input string n);
    logic [7:0] e;
    e = (a == ST) ? exp_st : ((a == EN) ? exp_en : 8'h00);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    if (a == ST) exp_st = 8'h00;
    chk_val(n, e, reg_rdata);
    chk_bit("irq_after_read", |(exp_st & exp_en), irq);
    @(posedge core_clk);
  endtask
  task automatic irq_chk();
    @(posedge core_clk);
    @(negedge core_clk);
    chk_bit("irq", |(exp_st & exp_en), irq);
    @(posedge core_clk);
  endtask

  // One frame strobe set on one buffer
  task automatic frame(input bit tx, input bit wr, input bit rd);
    logic ovf, und;
    int lv;
    lv = tx ? tx_lv : rx_lv;
    ovf = wr && !rd && lv == DEPTH;
    und = rd && !wr && lv == 0;
    if (wr && !rd && !ovf) lv++;
    if (rd && !wr && !und) lv--;
    if (tx) begin
      tx_frame_wr <= wr;
      tx_frame_rd <= rd;
      tx_lv = lv;
    end else begin
      rx_frame_wr <= wr;
      rx_frame_rd <= rd;
      rx_lv = lv;
    end
    @(posedge core_clk);
    tx_frame_wr <= 1'b0;
    tx_frame_rd <= 1'b0;
    rx_frame_wr <= 1'b0;
    rx_frame_rd <= 1'b0;
    @(negedge core_clk);
    chk_bit("drop", ovf, tx ? tx_frame_drop : rx_frame_drop);
    chk_bit("repeat", und, tx ? tx_frame_repeat : rx_frame_repeat);
    chk_val("level", 8'(lv), tx ? tx_level : rx_level);
    exp_st = exp_st | (exp_en & slip_bits(tx, ovf, und));
    irq_chk();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h4_0000;
    {tx_frame_wr, tx_frame_rd, rx_frame_wr, rx_frame_rd} = 4'h0;
    {miscompares, total_checks, cycles, tx_lv, rx_lv} = '0;
    exp_en = 8'h00;
    exp_st = 8'h00;
    seed = 33;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd_chk(EN, "enable_reset");
    rd_chk(ST, "status_reset");
    @(negedge core_clk);
    chk_bit("irq_reset", 1'b0, irq);
    @(posedge core_clk);
    reg_write(EN, 8'hff);
    rd_chk(EN, "enable_rw");
    rd_chk(8'h3c, "unmapped");
    $display("test reset_and_access done");
    // Each enable alone: overflow then underflow on both buffers
    for (int b = 0; b < 8; b++) begin
      reg_write(EN, 8'(1 << b));
      for (int t = 0; t < 2; t++) begin
        repeat (DEPTH + 1) frame(t[0], 1'b1, 1'b0);
        repeat (DEPTH + 1) frame(t[0], 1'b0, 1'b1);
        rd_chk(ST, "status_per_bit");
      end
    end
    $display("test per_bit_enable done");
    // Masking a pending event drops the interrupt, status still held
    reg_write(EN, 8'he7);
    repeat (DEPTH + 1) frame(1'b1, 1'b1, 1'b0);
    reg_write(EN, 8'h00);
    irq_chk();
    rd_chk(ST, "status_masked");
    rd_chk(ST, "status_cleared");
    $display("test mask done");
    // Random mix of slips and register accesses
    for (int i = 0; i < 80; i++) begin
      seed = xorshift(seed);
      r = seed;
      case (r[2:0])
        3'd4: reg_write(EN, r[15:8]);
        3'd5: rd_chk(ST, "status_random");
        3'd6: rd_chk(EN, "enable_random");
        3'd7: reg_write(ST, r[15:8]);
        default: frame(r[3], r[4], r[5]);
      endcase
    end
    rd_chk(ST, "status_final");
    $display("test random done");
    end_of_test();
  end

  // Verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
endmodule
